//--- rtl/dem_pkg.sv
// Purpose: Shared constants and carriers for the deserializer error monitor
// Assumes: 8-bit register port, one clock, synchronous active-high reset
// Notes: Offsets are the byte addresses of the register port
package dem_pkg;
	// ********************************
	// Register offsets
	// ********************************
	localparam logic [7:0] ADDR_EVT_CFG = 8'h2B;
	localparam logic [7:0] ADDR_ERR_CTL = 8'h2D;
	localparam logic [7:0] ADDR_LIM_LO = 8'h2E;
	localparam logic [7:0] ADDR_LIM_HI = 8'h2F;
	localparam logic [7:0] ADDR_EVT_CNT = 8'h3D;
	localparam logic [7:0] ADDR_ERR_LO = 8'h3E;
	localparam logic [7:0] ADDR_ERR_HI = 8'h3F;
	// ********************************
	// Field positions
	// ********************************
	localparam int EVT_EN_BIT = 0;
	localparam int EVT_RST_DATA_BIT = 1;
	localparam int EVT_RST_CDR_BIT = 2;
	localparam int EVT_SEL_BIT = 3;
	localparam int ERR_NOEXIT_BIT = 0;
	localparam int ERR_SEL_WIN_BIT = 1;
	localparam int ERR_CLEAR_BIT = 2;
	localparam int ERR_CODE_DIS_BIT = 3;
	localparam int ERR_ACCUM_BIT = 4;
	// ********************************
	// Reset values and masks
	// ********************************
	localparam logic [7:0] EVT_CFG_RST = 8'h00;
	localparam logic [7:0] ERR_CTL_RST = 8'h00;
	localparam logic [7:0] LIM_LO_RST = 8'h10;
	localparam logic [7:0] LIM_HI_RST = 8'h00;
	localparam logic [7:0] EVT_CFG_MASK = 8'h0F;
	localparam logic [7:0] ERR_CTL_MASK = 8'h1F;
	localparam int WINDOW_CYCLES = 1000000;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dem_req_s;
	typedef struct packed {
		logic clk_lost;
		logic lock_lost;
		logic data_err;
		logic code_err;
	} dem_evt_s;
endpackage : dem_pkg

//--- rtl/dem_monitor.sv
// Purpose: Error and event monitor of a serial video deserializer
// Assumes: Register port driven by on-chip logic in this clock domain
// Notes: Event pulses come from same-clock receive logic
// What this block does
// - Event counters count only when enabled
// - Select bit picks CDR or data counter
// - Bit 2 resets CDR event counter
// - Bit 1 resets data event counter
// - Accumulate bit keeps error counts across runs
// - Code-error disable masks count and lock
// - Clear bit zeroes current and previous counts
// - Select bit: current run or window count
// - No-exit bit keeps normal receiving state
// - Count above threshold stops data delivery
// - Threshold low byte resets to sixteen
// - Threshold high byte resets to zero
// - Selected event counter reads as byte
// - Error count reads as two bytes
`timescale 1ns/1ns
`default_nettype none
module dem_monitor #(
	parameter int WIN_CYCLES = dem_pkg::WINDOW_CYCLES
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire dem_pkg::dem_req_s REQ_I,
	input wire dem_pkg::dem_evt_s EVT_I,
	input wire logic LOCK_RAW_I,
	input wire logic [4:0] RX_DATA_I,
	output logic [7:0] RDATA_O,
	output logic LOCK_O,
	output logic RX_VALID_O,
	output logic [4:0] RX_DATA_O
);
	import dem_pkg::*;
	// Window end compares against WIN_CYCLES - 1 on a 32-bit timer
	if (WIN_CYCLES < 2) begin : g_win_check
		$error("WIN_CYCLES must be at least 2");
	end

	// Saturating so a stuck link cannot wrap back under the limit
	function automatic logic [7:0] sat8(input logic [7:0] v, input logic inc);
		sat8 = (inc && v != 8'hFF) ? v + 8'h01 : v;
	endfunction : sat8

	function automatic logic [15:0] sat16(input logic [15:0] v, input logic inc);
		sat16 = (inc && v != 16'hFFFF) ? v + 16'h0001 : v;
	endfunction : sat16

	typedef enum {ST_NORMAL, ST_HALTED} dem_state_e;

	logic [7:0] evt_cfg_q, evt_cfg_d, err_ctl_q, err_ctl_d;
	logic [7:0] lim_lo_q, lim_lo_d, lim_hi_q, lim_hi_d;
	logic [7:0] cdr_cnt_q, cdr_cnt_d, dat_cnt_q, dat_cnt_d;
	logic [15:0] run_cnt_q, run_cnt_d, win_cnt_q, win_cnt_d, prev_q, prev_d;
	logic [31:0] win_tmr_q, win_tmr_d;
	logic [7:0] rdata_q, rdata_d;
	logic lock_q, lock_d, valid_q, valid_d;
	logic [4:0] rxd_q, rxd_d;
	dem_state_e st_q, st_d;
	logic err_evt, win_end;
	logic [15:0] shown_cnt, limit;

	// ********************************
	// Configuration registers
	// ********************************
	always_comb begin
		evt_cfg_d = evt_cfg_q;
		err_ctl_d = err_ctl_q;
		lim_lo_d = lim_lo_q;
		lim_hi_d = lim_hi_q;
		if (REQ_I.wr) begin
			unique case (REQ_I.addr)
				ADDR_EVT_CFG: evt_cfg_d = REQ_I.wdata & EVT_CFG_MASK;
				ADDR_ERR_CTL: err_ctl_d = REQ_I.wdata & ERR_CTL_MASK;
				ADDR_LIM_LO: lim_lo_d = REQ_I.wdata;
				ADDR_LIM_HI: lim_hi_d = REQ_I.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			evt_cfg_q <= EVT_CFG_RST;
			err_ctl_q <= ERR_CTL_RST;
			lim_lo_q <= LIM_LO_RST;
			lim_hi_q <= LIM_HI_RST;
		end else begin
			evt_cfg_q <= evt_cfg_d;
			err_ctl_q <= err_ctl_d;
			lim_lo_q <= lim_lo_d;
			lim_hi_q <= lim_hi_d;
		end
	end

	// ********************************
	// Event and error counters
	// ********************************
	always_comb begin
		// Code errors dropped before they reach the count when the disable bit is set
		err_evt = EVT_I.data_err | (EVT_I.code_err & ~err_ctl_q[ERR_CODE_DIS_BIT]);
		// Timer runs free; a clear does not restart the window
		win_end = (win_tmr_q == 32'(WIN_CYCLES - 1));
		win_tmr_d = win_end ? 32'h0000_0000 : win_tmr_q + 32'h0000_0001;
		cdr_cnt_d = sat8(cdr_cnt_q, evt_cfg_q[EVT_EN_BIT]
			& (EVT_I.clk_lost | EVT_I.lock_lost));
		dat_cnt_d = sat8(dat_cnt_q, evt_cfg_q[EVT_EN_BIT] & err_evt);
		if (evt_cfg_q[EVT_RST_CDR_BIT]) begin
			cdr_cnt_d = 8'h00;
		end
		if (evt_cfg_q[EVT_RST_DATA_BIT]) begin
			dat_cnt_d = 8'h00;
		end
		run_cnt_d = sat16(run_cnt_q, err_evt);
		win_cnt_d = sat16(win_cnt_q, err_evt);
		prev_d = prev_q;
		if (win_end) begin
			// Window count restarts unless accumulation is on
			prev_d = win_cnt_d;
			if (!err_ctl_q[ERR_ACCUM_BIT]) begin
				win_cnt_d = 16'h0000;
			end
		end
		if (!LOCK_RAW_I && !err_ctl_q[ERR_ACCUM_BIT]) begin
			run_cnt_d = 16'h0000;
		end
		if (err_ctl_q[ERR_CLEAR_BIT]) begin
			run_cnt_d = 16'h0000;
			win_cnt_d = 16'h0000;
			prev_d = 16'h0000;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			cdr_cnt_q <= 8'h00;
			dat_cnt_q <= 8'h00;
			run_cnt_q <= 16'h0000;
			win_cnt_q <= 16'h0000;
			prev_q <= 16'h0000;
			win_tmr_q <= 32'h0000_0000;
		end else begin
			cdr_cnt_q <= cdr_cnt_d;
			dat_cnt_q <= dat_cnt_d;
			run_cnt_q <= run_cnt_d;
			win_cnt_q <= win_cnt_d;
			prev_q <= prev_d;
			win_tmr_q <= win_tmr_d;
		end
	end

	// ********************************
	// State, readback and outputs
	// ********************************
	always_comb begin
		// Window view shows last finished window for a stable read
		shown_cnt = err_ctl_q[ERR_SEL_WIN_BIT] ? prev_q : run_cnt_q;
		limit = {lim_hi_q, lim_lo_q};
		st_d = st_q;
		unique case (st_q)
			ST_NORMAL: begin
				if (shown_cnt > limit && !err_ctl_q[ERR_NOEXIT_BIT]) begin
					st_d = ST_HALTED;
				end
			end
			ST_HALTED: begin
				if (shown_cnt <= limit || err_ctl_q[ERR_NOEXIT_BIT]) begin
					st_d = ST_NORMAL;
				end
			end
		endcase
		// Code errors may not pull lock down when disabled
		lock_d = LOCK_RAW_I & ~(EVT_I.code_err & ~err_ctl_q[ERR_CODE_DIS_BIT]);
		// Halt blocks data in the same cycle the state leaves normal
		valid_d = (st_d == ST_NORMAL) & LOCK_RAW_I;
		rxd_d = valid_d ? RX_DATA_I : 5'h00;
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			lock_q <= 1'b0;
			valid_q <= 1'b0;
			rxd_q <= 5'h00;
			st_q <= ST_NORMAL;
		end else begin
			lock_q <= lock_d;
			valid_q <= valid_d;
			rxd_q <= rxd_d;
			st_q <= st_d;
		end
	end

	// ********************************
	// Register readback
	// ********************************
	// Registered decode; the two count bytes are not latched together
	always_comb begin
		rdata_d = 8'h00;
		unique case (REQ_I.addr)
			ADDR_EVT_CFG: rdata_d = evt_cfg_q;
			ADDR_ERR_CTL: rdata_d = err_ctl_q;
			ADDR_LIM_LO: rdata_d = lim_lo_q;
			ADDR_LIM_HI: rdata_d = lim_hi_q;
			ADDR_EVT_CNT: rdata_d = evt_cfg_q[EVT_SEL_BIT] ? dat_cnt_q : cdr_cnt_q;
			ADDR_ERR_LO: rdata_d = shown_cnt[7:0];
			ADDR_ERR_HI: rdata_d = shown_cnt[15:8];
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign RDATA_O = rdata_q;
	assign LOCK_O = lock_q;
	assign RX_VALID_O = valid_q;
	assign RX_DATA_O = rxd_q;
endmodule : dem_monitor
`default_nettype wire

//--- verification/dem_chk_properties.sv
// Purpose: Port checks of the error monitor
// Assumes: One clock, reset synchronous
// Notes: Bound to dem_monitor at the foot
`timescale 1ns/1ns
`default_nettype none
module dem_chk #(
	parameter int WIN_CYCLES = 16
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire dem_pkg::dem_req_s REQ_I,
	input wire dem_pkg::dem_evt_s EVT_I,
	input wire logic LOCK_RAW_I,
	input wire logic [4:0] RX_DATA_I,
	input wire logic [7:0] RDATA_O,
	input wire logic LOCK_O,
	input wire logic RX_VALID_O,
	input wire logic [4:0] RX_DATA_O
);
	import dem_pkg::*;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// ****************
	// Checks
	// ****************
	lock_raw_a: assert property (!LOCK_RAW_I |=> !LOCK_O)
		else $error("lock shown without raw lock");
	data_idle_a: assert property (!RX_VALID_O |-> RX_DATA_O == 5'h00)
		else $error("data driven while halted");
	data_pass_a: assert property (RX_VALID_O |-> RX_DATA_O == $past(RX_DATA_I))
		else $error("delivered data differs");
	evt_rsvd_a: assert property (REQ_I.addr == ADDR_EVT_CFG |=> RDATA_O[7:4] == 4'h0)
		else $error("reserved config bits set");
	ctl_rsvd_a: assert property (REQ_I.addr == ADDR_ERR_CTL |=> RDATA_O[7:5] == 3'h0)
		else $error("reserved control bits set");
	evt_back_a: assert property (REQ_I.wr && REQ_I.addr == ADDR_EVT_CFG ##1
		REQ_I.addr == ADDR_EVT_CFG |=> RDATA_O == ($past(REQ_I.wdata, 2) & 8'h0F))
		else $error("config readback wrong");
	lim_lo_a: assert property (REQ_I.wr && REQ_I.addr == ADDR_LIM_LO ##1
		REQ_I.addr == ADDR_LIM_LO |=> RDATA_O == $past(REQ_I.wdata, 2))
		else $error("limit low readback wrong");
	lim_hi_a: assert property (REQ_I.wr && REQ_I.addr == ADDR_LIM_HI ##1
		REQ_I.addr == ADDR_LIM_HI |=> RDATA_O == $past(REQ_I.wdata, 2))
		else $error("limit high readback wrong");
endmodule : dem_chk
bind dem_monitor dem_chk #(.WIN_CYCLES(WIN_CYCLES)) chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
	.REQ_I(REQ_I), .EVT_I(EVT_I), .LOCK_RAW_I(LOCK_RAW_I), .RX_DATA_I(RX_DATA_I),
	.RDATA_O(RDATA_O), .LOCK_O(LOCK_O), .RX_VALID_O(RX_VALID_O), .RX_DATA_O(RX_DATA_O));
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: Self-checking bench of the error monitor
// Assumes: Window shortened to 16 cycles
// Notes: Inputs move 1 ns after each edge
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import dem_pkg::*;
	localparam dem_evt_s EV_CLK = 4'h8;
	localparam dem_evt_s EV_DAT = 4'h2;
	localparam dem_evt_s EV_COD = 4'h1;
	logic CLK_I = 1'b0;
	logic SYS_RST_I = 1'b1;
	dem_req_s req = '0;
	dem_evt_s evt = '0;
	logic lock_raw = 1'b1;
	logic [4:0] rx_in = 5'h15;
	logic [7:0] rdata;
	logic lock;
	logic rx_valid;
	logic [4:0] rx_out;
	int miscompares = 0;
	int tests_run = 0;
	dem_monitor #(.WIN_CYCLES(16)) uut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .REQ_I(req),
		.EVT_I(evt), .LOCK_RAW_I(lock_raw), .RX_DATA_I(rx_in), .RDATA_O(rdata),
		.LOCK_O(lock), .RX_VALID_O(rx_valid), .RX_DATA_O(rx_out));
	initial begin
		forever #5 CLK_I = ~CLK_I;
	end
	// ****************
	// Shared tasks
	// ****************
	task automatic step(input int n = 1);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask : step
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		step();
		req.wr = 1'b0;
		// Idle edge so a following write never re-raises the strobe at once
		step();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req.addr = a;
		step(2);
		chk(rdata, e);
	endtask : rd
	task automatic pulse(input dem_evt_s v, input int n);
		evt = v;
		step(n);
		evt = '0;
	endtask : pulse
	task automatic lose_lock();
		lock_raw = 1'b0;
		step();
		lock_raw = 1'b1;
	endtask : lose_lock
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// ****************
	// Scenarios
	// ****************
	task automatic reset_values();
		rd(ADDR_EVT_CFG, 8'h00);
		rd(ADDR_ERR_CTL, 8'h00);
		rd(ADDR_LIM_LO, 8'h10);
		rd(ADDR_LIM_HI, 8'h00);
		rd(ADDR_ERR_HI, 8'h00);
	endtask : reset_values
	task automatic event_counts();
		pulse(EV_CLK, 1);
		rd(ADDR_EVT_CNT, 8'h00);
		wr(ADDR_EVT_CFG, 8'hF1);
		pulse(EV_CLK | 4'h4, 2);
		rd(ADDR_EVT_CNT, 8'h02);
		wr(ADDR_EVT_CFG, 8'h09);
		pulse(EV_DAT, 3);
		rd(ADDR_EVT_CNT, 8'h03);
		wr(ADDR_EVT_CFG, 8'h0B);
		pulse(EV_DAT, 1);
		rd(ADDR_EVT_CNT, 8'h00);
		wr(ADDR_EVT_CFG, 8'h09);
		pulse(EV_DAT, 1);
		rd(ADDR_EVT_CNT, 8'h01);
		wr(ADDR_EVT_CFG, 8'h05);
		rd(ADDR_EVT_CNT, 8'h00);
		wr(ADDR_EVT_CFG, 8'h01);
		pulse(EV_CLK, 300);
		rd(ADDR_EVT_CNT, 8'hFF);
	endtask : event_counts
	task automatic error_count();
		rd(ADDR_ERR_LO, 8'h05);
		lose_lock();
		rd(ADDR_ERR_LO, 8'h00);
		wr(ADDR_ERR_CTL, 8'hE8);
		rd(ADDR_ERR_CTL, 8'h08);
		pulse(EV_COD, 3);
		chk(lock, 8'h01);
		rd(ADDR_ERR_LO, 8'h00);
		wr(ADDR_ERR_CTL, 8'h00);
		pulse(EV_COD, 2);
		chk(lock, 8'h00);
		wr(ADDR_ERR_CTL, 8'h10);
		lose_lock();
		rd(ADDR_ERR_LO, 8'h02);
		wr(ADDR_ERR_CTL, 8'h14);
		rd(ADDR_ERR_LO, 8'h00);
	endtask : error_count
	task automatic threshold();
		wr(ADDR_ERR_CTL, 8'h00);
		wr(ADDR_LIM_LO, 8'h01);
		chk(rx_valid, 8'h01);
		pulse(EV_DAT, 2);
		step();
		chk(rx_valid, 8'h00);
		chk(rx_out, 8'h00);
		wr(ADDR_ERR_CTL, 8'h01);
		step();
		chk(rx_out, 8'h15);
		rx_in = 5'h0A;
		step();
		chk(rx_out, 8'h0A);
	endtask : threshold
	task automatic window();
		wr(ADDR_LIM_HI, 8'hFF);
		wr(ADDR_ERR_CTL, 8'h06);
		wr(ADDR_ERR_CTL, 8'h03);
		evt = EV_DAT;
		step(40);
		rd(ADDR_ERR_LO, 8'h10);
		wr(ADDR_ERR_CTL, 8'h06);
		rd(ADDR_ERR_LO, 8'h00);
		evt = '0;
	endtask : window
	initial begin
		step(3);
		SYS_RST_I = 1'b0;
		reset_values();
		event_counts();
		error_count();
		threshold();
		window();
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
